//--- hw/cdbi_pkg.sv
package cdbi_pkg;
   // ==========================================================
   // Bus widths
   localparam int CDBI_AW = 24;
   localparam int CDBI_DW = 32;
   localparam int CDBI_WW = 16;
   localparam int CDBI_PW = 16;
   localparam int CDBI_MSB = 23;
   // ==========================================================
   // Access sizes
   typedef enum logic [1:0] {
      CDBI_SZ_BYTE = 2'h0,
      CDBI_SZ_WORD = 2'h1,
      CDBI_SZ_LONG = 2'h3
   } cdbi_size_t;
   // ==========================================================
   // Peripheral window: word addresses from this base upward.
   localparam logic [23:0] CDBI_IO_BASE = 24'hFFF000;
   localparam logic [23:0] CDBI_ZERO_ADDR = 24'h000000;
   localparam logic [31:0] CDBI_ZERO_DATA = 32'h00000000;
   localparam logic [15:0] CDBI_ZERO_WORD = 16'h0000;
   // ==========================================================
   // Bus phase states
   typedef enum logic [1:0] {
      CDBI_IDLE = 2'h0,
      CDBI_DATA = 2'h1,
      CDBI_DUAL = 2'h3
   } cdbi_state_t;
endpackage

//--- hw/cdbi_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cdbi_decode (
   input wire logic [23:0] addr,
   input wire logic [1:0] size,
   output logic [23:0] eff_addr,
   output logic is_io
);
   import cdbi_pkg::*;
   // ==========================================================
   // Address shaping
   always_comb begin
      eff_addr = addr;
      if (size == CDBI_SZ_BYTE) begin
         eff_addr[CDBI_MSB] = 1'b0;
      end
      is_io = (eff_addr >= CDBI_IO_BASE);
   end
endmodule
`default_nettype wire

//--- hw/cdbi_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Primary read data returns on 32-bit read bus for primary address.
// - Primary write data comes from 32-bit write bus at primary address.
// - Primary address supports byte, word and long-word sizes.
// - Primary address also decodes memory-mapped peripheral registers.
// - Dual reads return second operand on 16-bit secondary read bus.
// - Secondary address serves second access only, words only.
// - Peripheral bus shares the data clock, adding no wait states.
// - Peripheral writes use primary write bus; reads return on primary read bus.
// - Byte accesses forced to lower half (address MSB zero) before decode, so they never reach peripherals.
// - Program memory writes use only low 16 write bits.
module cdbi_core (
   input wire logic clock,
   input wire logic rst,
   input wire logic core_rd,
   input wire logic core_wr,
   input wire logic core_pwr,
   input wire logic [1:0] core_size,
   input wire logic [cdbi_pkg::CDBI_AW-1:0] primary_data_address_bus,
   input wire logic [cdbi_pkg::CDBI_DW-1:0] core_wdata,
   output logic [cdbi_pkg::CDBI_DW-1:0] core_rdata,
   output logic core_rvalid,
   input wire logic core_rd2,
   input wire logic [cdbi_pkg::CDBI_AW-1:0] secondary_data_address_bus,
   output logic [cdbi_pkg::CDBI_WW-1:0] secondary_read_data_bus,
   output logic core_rvalid2,
   output logic mem_en,
   output logic mem_we,
   output logic [1:0] mem_size,
   output logic [cdbi_pkg::CDBI_AW-1:0] mem_addr,
   output logic [cdbi_pkg::CDBI_DW-1:0] mem_wdata,
   input wire logic [cdbi_pkg::CDBI_DW-1:0] mem_rdata,
   output logic mem2_en,
   output logic [cdbi_pkg::CDBI_AW-1:0] mem2_addr,
   input wire logic [cdbi_pkg::CDBI_WW-1:0] mem2_rdata,
   output logic per_en,
   output logic per_we,
   output logic [cdbi_pkg::CDBI_AW-1:0] per_addr,
   output logic [cdbi_pkg::CDBI_PW-1:0] peripheral_register_bus,
   input wire logic [cdbi_pkg::CDBI_PW-1:0] per_rdata,
   output logic pgm_we,
   output logic [cdbi_pkg::CDBI_AW-1:0] pgm_addr,
   output logic [cdbi_pkg::CDBI_WW-1:0] pgm_wdata
);
   import cdbi_pkg::*;

   logic [CDBI_AW-1:0] eff_addr;
   logic is_io;
   logic rd_io_r;
   logic [1:0] rd_size_r;
   cdbi_state_t state_r;
   cdbi_state_t state_nxt;

   cdbi_decode u_dec (
      .addr(primary_data_address_bus),
      .size(core_size),
      .eff_addr(eff_addr),
      .is_io(is_io)
   );

   // Size-aware extraction of returned data; narrow data sits low.
   function automatic logic [31:0] cdbi_fit(input logic [31:0] d, input logic [1:0] s);
      logic [31:0] r;
      r = d;
      if (s == CDBI_SZ_BYTE) begin
         r = {24'h000000, d[7:0]};
      end else if (s == CDBI_SZ_WORD) begin
         r = {16'h0000, d[15:0]};
      end
      return r;
   endfunction

   // ==========================================================
   // Address phase, combinational so no wait state is added
   always_comb begin
      mem_size = core_size;
      mem_addr = eff_addr;
      mem_wdata = core_wdata;
      mem_en = (core_rd | core_wr) & ~is_io & ~core_pwr;
      mem_we = core_wr & ~is_io & ~core_pwr;
      per_en = (core_rd | core_wr) & is_io & ~core_pwr;
      per_we = core_wr & is_io & ~core_pwr;
      per_addr = eff_addr;
      // peripheral write data from write bus
      peripheral_register_bus = core_wdata[CDBI_PW-1:0];
      pgm_we = core_wr & core_pwr;
      pgm_addr = primary_data_address_bus;
      pgm_wdata = core_wdata[CDBI_WW-1:0];
      // secondary bus is word-only read
      // The second read shares the primary read's gating, so it is never issued unanswered.
      mem2_en = core_rd2 & core_rd & ~core_pwr;
      mem2_addr = secondary_data_address_bus;
   end

   // ==========================================================
   // Data phase tracking
   always_comb begin
      state_nxt = CDBI_IDLE;
      if (core_rd & ~core_pwr) begin
         state_nxt = core_rd2 ? CDBI_DUAL : CDBI_DATA;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= CDBI_IDLE;
         rd_io_r <= 1'b0;
         rd_size_r <= CDBI_SZ_WORD;
      end else begin
         state_r <= state_nxt;
         rd_io_r <= is_io;
         rd_size_r <= core_size;
      end
   end

   // Read data is registered so the core sees a clean flop output.
   always_ff @(posedge clock) begin
      if (rst) begin
         core_rdata <= CDBI_ZERO_DATA;
         secondary_read_data_bus <= CDBI_ZERO_WORD;
      end else begin
         if (core_rd & ~core_pwr) begin
            core_rdata <= is_io ? {16'h0000, per_rdata}
                                : cdbi_fit(mem_rdata, core_size);
         end
         if (mem2_en) begin
            secondary_read_data_bus <= mem2_rdata;
         end
      end
   end

   always_comb begin
      case (state_r)
         CDBI_IDLE: begin
            core_rvalid = 1'b0;
            core_rvalid2 = 1'b0;
         end
         CDBI_DATA: begin
            core_rvalid = 1'b1;
            core_rvalid2 = 1'b0;
         end
         CDBI_DUAL: begin
            core_rvalid = 1'b1;
            core_rvalid2 = 1'b1;
         end
         default: begin
            core_rvalid = 1'b0;
            core_rvalid2 = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Checks
   // byte MSB cleared
   a_byte_msb_low: assert property (@(posedge clock) disable iff (rst)
      (core_size == CDBI_SZ_BYTE && mem_en) |-> !mem_addr[CDBI_MSB])
      else $error("byte access reached upper half");
   a_read_one_cycle: assert property (@(posedge clock) disable iff (rst)
      (core_rd && !core_pwr) |=> core_rvalid)
      else $error("read not answered in one cycle");
   a_read_data_mem: assert property (@(posedge clock) disable iff (rst)
      (core_rd && !core_pwr && !is_io && core_size == CDBI_SZ_LONG)
      |=> core_rdata == $past(mem_rdata))
      else $error("primary read data mismatch");
   a_per_read_data: assert property (@(posedge clock) disable iff (rst)
      (core_rd && !core_pwr && is_io) |=> core_rdata[15:0] == $past(per_rdata))
      else $error("peripheral read data mismatch");
   a_sec_read_data: assert property (@(posedge clock) disable iff (rst)
      mem2_en |=> (core_rvalid2 && secondary_read_data_bus == $past(mem2_rdata)))
      else $error("secondary read data mismatch");
   a_sec_with_pri: assert property (@(posedge clock) disable iff (rst)
      core_rvalid2 |-> core_rvalid)
      else $error("secondary answer without primary");
   a_one_target: assert property (@(posedge clock) disable iff (rst)
      !(mem_en && per_en) && !(pgm_we && (mem_en || per_en)))
      else $error("two targets selected");
   a_write_mem: assert property (@(posedge clock) disable iff (rst)
      (core_wr && !core_pwr && !is_io) |-> (mem_we && mem_wdata == core_wdata))
      else $error("write not forwarded");
   // valid lasts one cycle unless reissued
   a_valid_pulse: assert property (@(posedge clock) disable iff (rst)
      (core_rvalid && !$past(core_rd)) |-> 1'b0)
      else $error("stale read valid");
   a_narrow_zero: assert property (@(posedge clock) disable iff (rst)
      (core_rvalid && (rd_size_r == CDBI_SZ_BYTE || rd_size_r == CDBI_SZ_WORD))
      |-> (core_rdata[CDBI_DW-1:CDBI_PW] == CDBI_ZERO_WORD
      && (rd_size_r != CDBI_SZ_BYTE || core_rdata[15:8] == 8'h00)))
      else $error("narrow read data not zero-extended");
   a_per_upper_zero: assert property (@(posedge clock) disable iff (rst)
      (core_rvalid && rd_io_r) |-> core_rdata[CDBI_DW-1:CDBI_PW] == CDBI_ZERO_WORD)
      else $error("peripheral read upper half not zero");
   a_pgm_isolated: assert property (@(posedge clock) disable iff (rst)
      pgm_we |-> (!mem_we && !per_we && pgm_wdata == core_wdata[CDBI_WW-1:0]))
      else $error("program write leaked or lost data");
   c_mem_read: cover property (@(posedge clock) disable iff (rst)
      core_rd && !is_io ##1 core_rvalid);
   c_dual_read: cover property (@(posedge clock) disable iff (rst) core_rvalid2);
   c_per_write: cover property (@(posedge clock) disable iff (rst) per_we);
   c_pgm_write: cover property (@(posedge clock) disable iff (rst) pgm_we);
   c_byte_read: cover property (@(posedge clock) disable iff (rst)
      core_rd && core_size == CDBI_SZ_BYTE ##1 core_rvalid);
endmodule
`default_nettype wire

//--- tb/cdbi_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdbi_far_model (
   input wire logic clock,
   input wire logic mem_en,
   input wire logic [23:0] mem_addr,
   input wire logic mem2_en,
   input wire logic [23:0] mem2_addr,
   input wire logic per_en,
   input wire logic [23:0] per_addr,
   output logic [31:0] mem_rdata,
   output logic [15:0] mem2_rdata,
   output logic [15:0] per_rdata
);
   // Unselected ports show a pattern that moves every cycle, so stale data never matches.
   logic [31:0] junk_r = 32'h13579BDF;
   always_ff @(posedge clock) begin
      junk_r <= {junk_r[30:0], junk_r[31]};
   end
   assign mem_rdata = mem_en ? {8'hA5, mem_addr} : junk_r;
   assign mem2_rdata = mem2_en ? (mem2_addr[15:0] ^ 16'h5A5A) : junk_r[15:0];
   assign per_rdata = per_en ? (per_addr[15:0] ^ 16'h0F0F) : junk_r[31:16];
endmodule
`default_nettype wire

//--- tb/core_data_bus_interconnect_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_data_bus_interconnect_test;
   import cdbi_pkg::*;
   logic clock = 1'b0, rst = 1'b1, core_rd = 1'b0, core_wr = 1'b0, core_pwr = 1'b0;
   logic core_rd2 = 1'b0, core_rvalid, core_rvalid2, mem_en, mem_we, mem2_en;
   logic per_en, per_we, pgm_we;
   logic [1:0] core_size = 2'h0, mem_size;
   logic [23:0] primary_data_address_bus = 24'h0, secondary_data_address_bus = 24'h0;
   logic [23:0] mem_addr, mem2_addr, per_addr, pgm_addr;
   logic [31:0] core_wdata = 32'h0, core_rdata, mem_wdata, mem_rdata;
   logic [15:0] secondary_read_data_bus, mem2_rdata, peripheral_register_bus, per_rdata;
   logic [15:0] pgm_wdata;
   int errors = 0, total_checks = 0;
   always #2 clock = ~clock;
   cdbi_core dut (.clock, .rst, .core_rd, .core_wr, .core_pwr, .core_size,
      .primary_data_address_bus, .core_wdata, .core_rdata, .core_rvalid, .core_rd2,
      .secondary_data_address_bus, .secondary_read_data_bus, .core_rvalid2, .mem_en,
      .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_rdata, .mem2_en, .mem2_addr,
      .mem2_rdata, .per_en, .per_we, .per_addr, .peripheral_register_bus, .per_rdata,
      .pgm_we, .pgm_addr, .pgm_wdata);
   cdbi_far_model far (.clock, .mem_en, .mem_addr, .mem2_en, .mem2_addr, .per_en,
      .per_addr, .mem_rdata, .mem2_rdata, .per_rdata);
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic drive(input logic rd, wr, pwr, rd2, input logic [1:0] sz,
         input logic [23:0] a, a2, input logic [31:0] wd);
      @(posedge clock);
      #1;
      core_rd = rd;
      core_wr = wr;
      core_pwr = pwr;
      core_rd2 = rd2;
      core_size = sz;
      primary_data_address_bus = a;
      secondary_data_address_bus = a2;
      core_wdata = wd;
      #1;
   endtask
   task automatic idle;
      drive(1'b0, 1'b0, 1'b0, 1'b0, CDBI_SZ_WORD, 24'h0, 24'h0, 32'h0);
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_long_reads;
      drive(1'b1, 1'b0, 1'b0, 1'b0, CDBI_SZ_LONG, 24'h001234, 24'h0, 32'h0);
      chk(mem_en, 1'b1);
      chk(mem_addr, 24'h001234);
      chk(mem_size, CDBI_SZ_LONG);
      drive(1'b1, 1'b0, 1'b0, 1'b0, CDBI_SZ_LONG, 24'h004321, 24'h0, 32'h0);
      chk(core_rvalid, 1'b1);
      chk(core_rdata, 32'hA5001234);
      idle();
      chk(core_rdata, 32'hA5004321);
      idle();
      chk(core_rvalid, 1'b0);
   endtask
   task automatic t_writes;
      drive(1'b0, 1'b1, 1'b0, 1'b0, CDBI_SZ_LONG, 24'h000100, 24'h0, 32'hDEADBEEF);
      chk({mem_we, mem_addr}, {1'b1, 24'h000100});
      chk(mem_wdata, 32'hDEADBEEF);
      drive(1'b0, 1'b1, 1'b1, 1'b0, CDBI_SZ_WORD, 24'h000200, 24'h0, 32'hCAFE1234);
      chk({pgm_we, pgm_addr}, {1'b1, 24'h000200});
      chk(pgm_wdata, 16'h1234);
      chk({mem_en, per_en}, 2'h0);
      idle();
      chk(core_rvalid, 1'b0);
   endtask
   task automatic t_sizes;
      drive(1'b1, 1'b0, 1'b0, 1'b0, CDBI_SZ_BYTE, 24'h8000C3, 24'h0, 32'h0);
      chk(mem_addr, 24'h0000C3);
      chk(mem_size, CDBI_SZ_BYTE);
      drive(1'b1, 1'b0, 1'b0, 1'b0, CDBI_SZ_WORD, 24'h800010, 24'h0, 32'h0);
      chk(core_rdata, 32'h000000C3);
      chk(mem_addr, 24'h800010);
      chk(mem_size, CDBI_SZ_WORD);
      idle();
      chk(core_rdata, 32'h00000010);
   endtask
   task automatic t_peripheral;
      drive(1'b0, 1'b1, 1'b0, 1'b0, CDBI_SZ_WORD, 24'hFFF010, 24'h0, 32'h0000BEEF);
      chk({per_en, per_we, per_addr}, {2'h3, 24'hFFF010});
      chk(peripheral_register_bus, 16'hBEEF);
      drive(1'b1, 1'b0, 1'b0, 1'b0, CDBI_SZ_WORD, 24'hFFF010, 24'h0, 32'h0);
      chk({per_en, per_we}, 2'h2);
      idle();
      chk({core_rvalid, core_rdata}, {1'b1, 32'h0000FF1F});
   endtask
   task automatic t_dual;
      drive(1'b1, 1'b0, 1'b0, 1'b1, CDBI_SZ_WORD, 24'h000300, 24'h000400, 32'h0);
      chk({mem2_en, mem2_addr}, {1'b1, 24'h000400});
      idle();
      chk({core_rvalid2, secondary_read_data_bus}, {1'b1, 16'h5E5A});
      chk(core_rdata, 32'h00000300);
      drive(1'b0, 1'b0, 1'b0, 1'b1, CDBI_SZ_WORD, 24'h0, 24'h000500, 32'h0);
      chk(mem2_en, 1'b0);
      idle();
      chk(core_rvalid2, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      #1;
      rst = 1'b0;
      t_long_reads();
      t_writes();
      t_sizes();
      t_peripheral();
      t_dual();
      end_sim();
   end
endmodule
`default_nettype wire
